/* nvsc_pkg.sv */
// Purpose: constants for the shadow SRAM host controller
// Assumes: 200 MHz clock, 5 ns period
// Notes: pin timing figures kept in ns, us or ms, cycle counts derived
package nvsc_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// Read access allowance, slowest grade
	localparam int READ_ACCESS_NS = 45;
	// Data pins pass three flops, so their latency is added to the access time
	localparam int SYNC_STAGES = 3;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	// Slow write set with output drive low not used; host keeps it high
	localparam int WRITE_PULSE_NS = 35;
	localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_NS = 5;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STORE_INIT_NS = 25;
	localparam int STORE_INIT_CYC = (STORE_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STORE_MS = 10;
	localparam int STORE_CYC = STORE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RECALL_US = 20;
	localparam int RECALL_CYC = RECALL_US * 1000 / CLK_PERIOD_NS;
	localparam int WAIT_W = 22;
	localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	typedef enum logic [2:0] {
		NVSC_IDLE = 3'b000,
		NVSC_SETUP = 3'b001,
		NVSC_STROBE = 3'b010,
		NVSC_HOLD = 3'b011,
		NVSC_WAIT = 3'b100,
		NVSC_POWER = 3'b101
	} nvsc_state_type;
	typedef enum logic [1:0] {
		NVSC_CMD_READ = 2'b00,
		NVSC_CMD_WRITE = 2'b01,
		NVSC_CMD_STORE = 2'b10,
		NVSC_CMD_RECALL = 2'b11
	} nvsc_cmd_type;
endpackage : nvsc_pkg

/* nvsc_host.sv */
// Purpose: host controller driving the pins of an 8K x 8 shadow SRAM
// Assumes: one command at a time; device pins sampled through three flops
// Notes: every transfer ends with all strobes high, so each STORE or RECALL
//   starts on a fresh pin transition
`timescale 1ns/1ps
module nvsc_host
	import nvsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire nvsc_cmd_type cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	input wire logic supply_ok,
	output logic store_refused,
	output logic [ADDR_W-1:0] mem_addr,
	output logic chip_sel_n,
	output logic wr_strobe_n,
	output logic out_drive_n,
	output logic nv_sel_n,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);
	typedef struct packed {
		nvsc_state_type state;
		nvsc_cmd_type op;
		logic [WAIT_W-1:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rsp;
		logic refused;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic nv_n;
		logic drive;
		logic [2:0] sup_sync;
		logic sup_stable;
		logic [DATA_W-1:0] dq_s1;
		logic [DATA_W-1:0] dq_s2;
		logic [DATA_W-1:0] dq_s3;
	} nvsc_regs_type;

	nvsc_regs_type r_q;
	nvsc_regs_type r_d;

	always_comb begin
		r_d = r_q;
		r_d.rsp = 1'b0;
		r_d.refused = 1'b0;
		r_d.sup_sync = {r_q.sup_sync[1:0], supply_ok};
		// Accept a supply change only once the last two stages agree
		if (r_q.sup_sync[2] == r_q.sup_sync[1]) begin
			r_d.sup_stable = r_q.sup_sync[1];
		end
		r_d.dq_s1 = dq_in;
		r_d.dq_s2 = r_q.dq_s1;
		r_d.dq_s3 = r_q.dq_s2;
		if (r_q.cnt != '0) begin
			r_d.cnt = r_q.cnt - 1'b1;
		end
		case (r_q.state)
			NVSC_POWER: begin
				if (r_q.sup_stable == 1'b0) begin
					r_d.cnt = WAIT_W'(RECALL_CYC);
				end else if (r_q.cnt == '0) begin
					r_d.state = NVSC_IDLE;
				end
			end
			NVSC_IDLE: begin
				if (r_q.sup_stable == 1'b0) begin
					r_d.state = NVSC_POWER;
					r_d.cnt = WAIT_W'(RECALL_CYC);
				end else if (cmd_valid) begin
					r_d.op = cmd_op;
					r_d.addr = cmd_addr;
					r_d.wdata = cmd_wdata;
					r_d.cnt = WAIT_W'(SETUP_CYC);
					if (cmd_op == NVSC_CMD_STORE && !r_q.sup_stable) begin
						r_d.refused = 1'b1;
						r_d.state = NVSC_IDLE;
					end else begin
						r_d.state = NVSC_SETUP;
					end
					// Output drive high before any select falls
					r_d.oe_n = 1'b1;
					r_d.we_n = 1'b1;
					r_d.ce_n = 1'b1;
					r_d.nv_n = (cmd_op == NVSC_CMD_STORE || cmd_op == NVSC_CMD_RECALL) ?
						1'b0 : 1'b1;
					r_d.drive = (cmd_op == NVSC_CMD_WRITE);
				end
			end
			NVSC_SETUP: begin
				if (r_q.cnt == '0) begin
					r_d.state = NVSC_STROBE;
					r_d.ce_n = 1'b0;
					case (r_q.op)
						NVSC_CMD_READ: begin
							r_d.oe_n = 1'b0;
							r_d.cnt = WAIT_W'(READ_CYC);
						end
						NVSC_CMD_WRITE: begin
							r_d.we_n = 1'b0;
							r_d.cnt = WAIT_W'(WRITE_CYC);
						end
						NVSC_CMD_STORE: begin
							// Chip select first, write strobe falls last
							r_d.cnt = WAIT_W'(SETUP_CYC);
						end
						default: begin
							r_d.oe_n = 1'b0;
							r_d.cnt = WAIT_W'(STORE_INIT_CYC);
						end
					endcase
				end
			end
			NVSC_STROBE: begin
				if (r_q.op == NVSC_CMD_STORE && r_q.we_n) begin
					if (r_q.cnt == '0) begin
						r_d.we_n = 1'b0;
						r_d.cnt = WAIT_W'(STORE_INIT_CYC);
					end
				end else if (r_q.cnt == '0 &&
					(r_q.op != NVSC_CMD_READ || r_q.dq_s2 == r_q.dq_s3)) begin
					// Read data counts only once the last two stages agree;
					// a silent device stalls here, floating lines seldom agree
					r_d.state = NVSC_HOLD;
					if (r_q.op == NVSC_CMD_READ) begin
						r_d.rdata = r_q.dq_s3;
						r_d.rsp = 1'b1;
					end
					// End initiation by raising every strobe
					r_d.ce_n = 1'b1;
					r_d.we_n = 1'b1;
					r_d.oe_n = 1'b1;
					r_d.cnt = WAIT_W'(SETUP_CYC);
				end
			end
			NVSC_HOLD: begin
				if (r_q.cnt == '0) begin
					r_d.drive = 1'b0;
					r_d.nv_n = 1'b1;
					if (r_q.op == NVSC_CMD_STORE) begin
						r_d.state = NVSC_WAIT;
						r_d.cnt = WAIT_W'(STORE_CYC);
					end else if (r_q.op == NVSC_CMD_RECALL) begin
						r_d.state = NVSC_WAIT;
						r_d.cnt = WAIT_W'(RECALL_CYC);
					end else begin
						r_d.state = NVSC_IDLE;
					end
				end
			end
			NVSC_WAIT: begin
				// Supply loss aborts a STORE; fall back to power wait
				if (!r_q.sup_stable) begin
					r_d.state = NVSC_POWER;
					r_d.cnt = WAIT_W'(RECALL_CYC);
				end else if (r_q.cnt == '0) begin
					r_d.state = NVSC_IDLE;
					r_d.rsp = 1'b1;
				end
			end
			default: begin
				r_d.state = NVSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r_q <= '{state: NVSC_POWER, op: NVSC_CMD_READ, cnt: WAIT_W'(RECALL_CYC),
				addr: ADDR_RST, wdata: DATA_RST, rdata: DATA_RST, rsp: 1'b0,
				refused: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, nv_n: 1'b1,
				drive: 1'b0, sup_sync: 3'h0, sup_stable: 1'b0, dq_s1: DATA_RST,
				dq_s2: DATA_RST, dq_s3: DATA_RST};
		end else if (clk_en) begin
			r_q <= r_d;
		end
	end

	assign cmd_ready = (r_q.state == NVSC_IDLE) && r_q.sup_stable;
	assign rsp_valid = r_q.rsp;
	assign rsp_rdata = r_q.rdata;
	assign store_refused = r_q.refused;
	assign mem_addr = r_q.addr;
	assign chip_sel_n = r_q.ce_n;
	assign wr_strobe_n = r_q.we_n;
	assign out_drive_n = r_q.oe_n;
	assign nv_sel_n = r_q.nv_n;
	assign dq_out = r_q.wdata;
	assign dq_oe = r_q.drive;

	a_write_no_oe: assert property (@(posedge clock) disable iff (rst)
		!wr_strobe_n |-> out_drive_n)
		else $error("output drive low during write strobe");
	a_drive_in_write: assert property (@(posedge clock) disable iff (rst)
		dq_oe |-> (nv_sel_n && out_drive_n))
		else $error("data driven outside a write");
	a_store_hold: assert property (@(posedge clock) disable iff (rst)
		$fell(wr_strobe_n) && !nv_sel_n && clk_en [*1] |-> !wr_strobe_n [*5])
		else $error("STORE condition held too briefly");
	a_store_oe_high: assert property (@(posedge clock) disable iff (rst)
		(!nv_sel_n && !chip_sel_n && !wr_strobe_n) |-> out_drive_n)
		else $error("STORE with output drive low");
	a_addr_stable: assert property (@(posedge clock) disable iff (rst)
		!wr_strobe_n |-> $stable(mem_addr))
		else $error("address moved during write");
	a_oe_first: assert property (@(posedge clock) disable iff (rst)
		$fell(nv_sel_n) |-> $past(out_drive_n))
		else $error("output drive not high before select fell");
	a_no_cmd_lowsup: assert property (@(posedge clock) disable iff (rst)
		!r_q.sup_stable |-> !cmd_ready)
		else $error("command accepted with supply low");
	a_idle_strobes: assert property (@(posedge clock) disable iff (rst)
		cmd_ready |-> (chip_sel_n && wr_strobe_n && out_drive_n))
		else $error("strobes not released between transfers");
endmodule : nvsc_host

/* nvsc_dev_model.sv */
// Purpose: pin-level model of the shadow SRAM seen by the host
// Assumes: whole-array copies happen at the end of the cycle time
// Notes: undriven data lines toggle so stale values never pass
`timescale 1ns/1ps
module nvsc_dev_model #(
	parameter int ACC_NS = 40,
	parameter int REC_NS = 20000,
	parameter int STO_NS = 10000000
) (
	input wire logic [12:0] addr,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic nv_sel_n,
	input wire logic [7:0] hdq,
	input wire logic hoe,
	input wire logic vsense,
	output logic [7:0] dq,
	output logic busy,
	output int n_store,
	output int n_recall,
	output int clash
);
	logic [7:0] mem [0:8191];
	logic [7:0] nv [0:8191];
	logic [7:0] flt = 8'h5a;
	logic kind = 1'b0;
	wire rd = !ce_n && !oe_n && we_n && nv_sel_n && !busy;
	wire wr = !ce_n && !we_n && nv_sel_n && !busy;
	wire sc = !ce_n && !we_n && oe_n && !nv_sel_n;
	wire rc = !ce_n && !oe_n && we_n && !nv_sel_n;
	wire rd_d;
	assign #(ACC_NS) rd_d = rd;
	wire drv = rd && rd_d;
	wire both = drv && hoe;
	initial begin
		busy = 1'b0;
		n_store = 0;
		n_recall = 0;
		clash = 0;
		foreach (nv[i]) nv[i] = 8'(i) ^ {5'(i >> 8), 3'h5};
	end
	always #5 flt = ~flt;
	// Host drive wins so contention is counted, not hidden
	assign dq = hoe ? hdq : (drv ? mem[addr] : flt);
	always @(posedge both) clash++;
	always @(negedge wr) mem[addr] = dq;
	always @(posedge sc) if (!busy && vsense) begin
		n_store++;
		kind = 1'b1;
		busy = 1'b1;
	end
	always @(posedge rc) if (!busy) begin
		n_recall++;
		busy = 1'b1;
	end
	always @(posedge vsense) begin
		n_recall++;
		busy = 1'b1;
	end
	always @(negedge vsense) if (kind) begin
		disable run;
		kind = 1'b0;
		busy = 1'b0;
	end
	always @(posedge busy) begin : run
		if (kind) begin
			#(STO_NS);
			nv = mem;
		end else begin
			#(REC_NS);
			foreach (mem[i]) mem[i] = 8'h00;
			mem = nv;
		end
		kind = 1'b0;
		busy = 1'b0;
	end
endmodule : nvsc_dev_model

/* test_nv_shadow_sram_control.sv */
// Purpose: self-checking bench for the shadow SRAM host controller
// Assumes: device model on the far side shares the supply sense
// Notes: a full STORE lasts 10 ms, so only its start and abort run
`timescale 1ns/1ps
module test_nv_shadow_sram_control;
	import nvsc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic cmd_valid = 1'b0;
	logic supply_ok = 1'b0;
	logic rnd = 1'b0;
	nvsc_cmd_type cmd_op = NVSC_CMD_READ;
	logic [ADDR_W-1:0] cmd_addr = 13'h0000;
	logic [DATA_W-1:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, store_refused, chip_sel_n, wr_strobe_n, out_drive_n;
	logic nv_sel_n, dq_oe, busy;
	logic [ADDR_W-1:0] mem_addr, a;
	logic [DATA_W-1:0] rsp_rdata, dq_in, dq_out, got;
	logic [DATA_W-1:0] exp_mem [0:8191];
	int err_total = 0;
	int checks = 0;
	int seed = 58415;
	int cyc = 0;
	int n_refused = 0;
	int t0, n_store, n_recall, clash, k;
	nvsc_host nvsc_host_i (.clock, .rst, .clk_en, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
		.cmd_wdata, .rsp_valid, .rsp_rdata, .supply_ok, .store_refused, .mem_addr, .chip_sel_n,
		.wr_strobe_n, .out_drive_n, .nv_sel_n, .dq_in, .dq_out, .dq_oe);
	nvsc_dev_model nvsc_dev_model_i (.addr(mem_addr), .ce_n(chip_sel_n), .we_n(wr_strobe_n),
		.oe_n(out_drive_n), .nv_sel_n(nv_sel_n), .hdq(dq_out), .hoe(dq_oe), .vsense(supply_ok),
		.dq(dq_in), .busy(busy), .n_store(n_store), .n_recall(n_recall), .clash(clash));
	always #2.5 clock = ~clock;
	// Refusal pulse is registered; look at it away from its launching edge
	always @(negedge clock) if (store_refused === 1'b1) n_refused++;
	always @(posedge clock) #1 clk_en = rnd ? ($random(seed) % 4 != 0) : 1'b1;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			stop_test();
		end
	end
	function automatic logic [7:0] nv_pat(input logic [12:0] i);
		return i[7:0] ^ {i[12:8], 3'h5};
	endfunction : nv_pat
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic send(input nvsc_cmd_type op, input logic [12:0] ra, input logic [7:0] d);
		int n = 0;
		@(posedge clock);
		#1 cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = ra;
		cmd_wdata = d;
		do begin
			@(negedge clock);
			n++;
		end while (!(cmd_ready === 1'b1 && clk_en === 1'b1) && n < 9000);
		check("accept", 1, n < 9000);
		@(posedge clock);
		#1 cmd_valid = 1'b0;
	endtask : send
	task automatic wait_rsp();
		int n = 0;
		while (rsp_valid !== 1'b1 && n < 9000) begin
			@(negedge clock);
			n++;
		end
		got = rsp_rdata;
		check("rsp_valid", 1, rsp_valid);
	endtask : wait_rsp
	task automatic rd_chk(input logic [12:0] ra);
		send(NVSC_CMD_READ, ra, 8'h00);
		wait_rsp();
		check("rsp_rdata", exp_mem[ra], got);
	endtask : rd_chk
	task automatic wait_ready();
		int n = 0;
		while (cmd_ready !== 1'b1 && n < 9000) begin
			@(negedge clock);
			n++;
		end
		check("cmd_ready", 1, cmd_ready);
		check("ready delay", 1, (cyc - t0) >= RECALL_CYC);
		check("device busy", 0, busy);
	endtask : wait_ready
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		foreach (exp_mem[i]) exp_mem[i] = nv_pat(13'(i));
		repeat (12) @(posedge clock);
		#1 rst = 1'b0;
		repeat (4) @(posedge clock);
		#1 supply_ok = 1'b1;
		t0 = cyc;
		wait_ready();
		rd_chk(13'h0000);
		rd_chk(13'h1fff);
		$display("test power-up done, errors %0d", err_total);
		rnd = 1'b1;
		for (k = 0; k < 10; k++) begin
			a = (k < 2) ? {13{k[0]}} : 13'($random(seed));
			exp_mem[a] = 8'($random(seed));
			send(NVSC_CMD_WRITE, a, exp_mem[a]);
			rd_chk(a);
		end
		rnd = 1'b0;
		check("contention", 0, clash);
		$display("test write-read done, errors %0d", err_total);
		t0 = n_recall;
		send(NVSC_CMD_RECALL, a, 8'h00);
		wait_rsp();
		check("recall count", t0 + 1, n_recall);
		foreach (exp_mem[i]) exp_mem[i] = nv_pat(13'(i));
		rd_chk(a);
		$display("test recall done, errors %0d", err_total);
		send(NVSC_CMD_WRITE, a, ~exp_mem[a]);
		send(NVSC_CMD_STORE, a, 8'h00);
		repeat (20) @(negedge clock);
		check("store count", 1, n_store);
		check("dq_oe", 0, dq_oe);
		@(posedge clock);
		#1 supply_ok = 1'b0;
		repeat (20) @(negedge clock);
		check("cmd_ready", 0, cmd_ready);
		@(posedge clock);
		#1 supply_ok = 1'b1;
		t0 = cyc;
		wait_ready();
		check("store count", 1, n_store);
		rd_chk(a);
		check("store_refused", 0, n_refused);
		$display("test store abort done, errors %0d", err_total);
		stop_test();
	end
endmodule : test_nv_shadow_sram_control
